// [pkg/iab_pkg.sv]
package iab_pkg;

   // Datapath widths
   localparam int XLEN   = 32;
   localparam int IMM_W  = 16;
   localparam int RIDX_W = 5;
   localparam int NREGS  = 32;
   localparam int BYTE_W = 8;
   localparam int LANES  = 4;

   // Instruction field positions (bit 31 is the leftmost opcode bit)
   localparam int OPC_HI   = 31;
   localparam int OPC_W    = 6;
   localparam int MAJ_W    = 3;
   localparam int BIT_KEEP = 28;
   localparam int BIT_CIN  = 27;
   localparam int BIT_RSV  = 26;
   localparam int BIT_DLY  = 25;
   localparam int RD_LO    = 21;
   localparam int RA_LO    = 16;
   localparam int RB_LO    = 11;
   localparam int PAD_HI   = 24;
   localparam int PAD_W    = 4;
   localparam int TAIL_W   = 11;

   // Opcode values
   localparam logic [2:0] MAJ_ADD   = 3'h0;
   localparam logic [2:0] MAJ_ADDI  = 3'h1;
   localparam logic [5:0] OPC_AND   = 6'h21;
   localparam logic [5:0] OPC_ANDI  = 6'h29;
   localparam logic [5:0] OPC_ANDN  = 6'h23;
   localparam logic [5:0] OPC_ANDNI = 6'h2b;
   localparam logic [5:0] OPC_BRZ   = 6'h27;

   // Program counter
   localparam logic [31:0] PC_STEP = 32'h0000_0004;
   localparam logic [31:0] PC_RST  = 32'h0000_0000;

   // Branch occupancy in cycles
   localparam int CYC_TAKEN_DLY = 2;
   localparam int CYC_TAKEN     = 3;
   localparam logic [1:0] STALL_LAST = 2'h1;

   // Wishbone register map (byte addresses)
   localparam int WB_AW = 8;
   localparam logic [7:0] ADR_CTRL     = 8'h00;
   localparam logic [7:0] ADR_STATUS   = 8'h04;
   localparam logic [7:0] ADR_PC       = 8'h08;
   localparam logic [7:0] ADR_REG_IDX  = 8'h0c;
   localparam logic [7:0] ADR_REG_DATA = 8'h10;

   // Register bit positions
   localparam int CTRL_RUN  = 0;
   localparam int ST_CARRY  = 0;
   localparam int ST_TRAP   = 1;
   localparam int ST_UNSUP  = 2;
   localparam int ST_SLOT   = 3;

   // Execution phase
   typedef enum logic [1:0] {PH_ISSUE, PH_STALL, PH_SLOT} iab_phase_t;

   // Arithmetic/logic operation
   typedef enum logic [1:0] {ALU_ADD, ALU_AND, ALU_ANDN} iab_alu_op_t;

   typedef struct packed {
      iab_alu_op_t       op;
      logic [XLEN-1:0]   a;
      logic [XLEN-1:0]   b;
      logic              cin;
   } iab_alu_req_t;

   typedef struct packed {
      logic [XLEN-1:0]   res;
      logic              cout;
   } iab_alu_rsp_t;

   // Word offered by the fetch stage
   typedef struct packed {
      logic              valid;
      logic [XLEN-1:0]   word;
      logic              pfx_valid;
      logic [IMM_W-1:0]  pfx_hi;
   } iab_instr_t;

endpackage

// [src/iab_alu.sv]
`timescale 1ns/10ps
// Sum and bitwise results for one operand pair
module iab_alu (
   // Operation request
   input  wire iab_pkg::iab_alu_req_t req_i,
   // Result
   output iab_pkg::iab_alu_rsp_t      rsp_o
);

   logic [iab_pkg::XLEN:0] sum; // One extra bit holds the carry-out

   // Adder always runs; the op only picks the result
   always_comb begin
      sum = {1'b0, req_i.a} + {1'b0, req_i.b}
          + {{iab_pkg::XLEN{1'b0}}, req_i.cin};
      rsp_o.cout = sum[iab_pkg::XLEN];
      case (req_i.op)
         iab_pkg::ALU_AND:  rsp_o.res = req_i.a & req_i.b;
         iab_pkg::ALU_ANDN: rsp_o.res = req_i.a & ~req_i.b;
         default:           rsp_o.res = sum[iab_pkg::XLEN-1:0];
      endcase
   end

endmodule // iab_alu

// [src/iab_exec.sv]
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/10ps
// Functional notes
// - Add family: major 000, keep/carry bits
// - Add writes sum of both sources
// - Keep bit freezes carry, else carry-out
// - Carry-in bit adds current carry flag
// - All-zero word traps when parameter set
// - Immediate add uses sign-extended literal
// - Prefix supplies upper literal half instead
// - AND writes source A and B
// - AND immediate uses sign-extended literal
// - AND-NOT complements source B
// - AND-NOT immediate complements extended literal
// - Branch-zero decode, delay flag, zero padding
// - Zero source A jumps PC plus B, except in the slot
// - Delay flag lets next word complete
// - One, two or three cycle branches
module iab_exec #(
   parameter bit zero_word_trap_param = 1'b1 // Trap the all-zero word
) (
   // Clock and reset
   input  wire  logic                      clk_i,
   input  wire  logic                      rst_i,
   // Fetch side
   input  wire  iab_pkg::iab_instr_t       instr_i,
   output logic                            instr_ready_o,
   output logic [iab_pkg::XLEN-1:0]        pc_o,
   // Status
   output logic                            carry_o,
   output logic                            trap_o,
   output logic                            slot_o,
   // Wishbone slave
   input  wire  logic                      wb_cyc_i,
   input  wire  logic                      wb_stb_i,
   input  wire  logic                      wb_we_i,
   input  wire  logic [iab_pkg::WB_AW-1:0] wb_adr_i,
   input  wire  logic [iab_pkg::LANES-1:0] wb_sel_i,
   input  wire  logic [iab_pkg::XLEN-1:0]  wb_dat_i,
   output logic [iab_pkg::XLEN-1:0]        wb_dat_o,
   output logic                            wb_ack_o
);

   typedef logic [iab_pkg::XLEN-1:0] iab_word_t;

   // Whole block state
   typedef struct packed {
      iab_pkg::iab_phase_t             phase;  // Issue, bubble or slot
      logic [1:0]                      stall;  // Bubbles left
      logic                            dly;    // Slot follows bubbles
      iab_word_t                       pc;     // Address being fetched
      iab_word_t                       target; // Pending branch target
      logic                            carry;  // Status carry flag
      logic                            run;    // Software run enable
      logic                            trap;   // Sticky zero-word trap
      logic                            unsup;  // Sticky unknown word
      logic                            trap_p; // One-cycle trap pulse
      logic                            ready;  // Offer to fetch
      logic                            slot;   // Slot word is next
      logic [iab_pkg::RIDX_W-1:0]      ridx;   // Bus window register
      logic                            ack;    // Bus answer
      iab_word_t                       rdata;  // Bus read data
      logic [iab_pkg::NREGS-1:0][iab_pkg::XLEN-1:0] regs; // Register file
   } iab_state_t;

   iab_state_t s_ff;    // Registered state
   iab_state_t nxt_s;   // Next state

   // Decode
   iab_word_t                   word;      // Offered word
   logic                        fire;      // Word taken this cycle
   logic [iab_pkg::OPC_W-1:0]   opc;       // Top six bits
   logic [iab_pkg::RIDX_W-1:0]  rd;        // Destination index
   logic [iab_pkg::RIDX_W-1:0]  ra;        // Source A index
   logic [iab_pkg::RIDX_W-1:0]  rb;        // Source B index
   logic                        tail_zero; // Low padding clear
   logic                        is_add;    // Register add family
   logic                        is_addi;   // Immediate add family
   logic                        is_and;    // AND
   logic                        is_andi;   // AND immediate
   logic                        is_andn;   // AND-NOT
   logic                        is_andni;  // AND-NOT immediate
   logic                        is_br;     // Branch if source A zero
   logic                        is_ztrap;  // All-zero word trapped
   logic                        is_imm;    // Literal operand form
   iab_word_t                   opa;       // Source A value
   iab_word_t                   opb;       // Source B value
   iab_word_t                   sext_imm;  // Sign-extended literal
   iab_word_t                   imm_op;    // Literal operand used
   iab_word_t                   br_tgt;    // Taken branch target
   iab_word_t                   step_pc;   // Address after this word
   iab_pkg::iab_alu_req_t       alu_req;   // Operand request
   iab_pkg::iab_alu_rsp_t       alu_rsp;   // Result

   assign word      = instr_i.word;
   assign fire      = instr_i.valid & s_ff.ready;
   assign opc       = word[iab_pkg::OPC_HI -: iab_pkg::OPC_W];
   assign rd        = word[iab_pkg::RD_LO +: iab_pkg::RIDX_W];
   assign ra        = word[iab_pkg::RA_LO +: iab_pkg::RIDX_W];
   assign rb        = word[iab_pkg::RB_LO +: iab_pkg::RIDX_W];
   assign tail_zero = word[iab_pkg::TAIL_W-1:0] == '0;

   // Add families share major field and reserved bit
   assign is_add  = word[iab_pkg::OPC_HI -: iab_pkg::MAJ_W] ==
                    iab_pkg::MAJ_ADD && !word[iab_pkg::BIT_RSV] &&
                    tail_zero;
   assign is_addi = word[iab_pkg::OPC_HI -: iab_pkg::MAJ_W] ==
                    iab_pkg::MAJ_ADDI && !word[iab_pkg::BIT_RSV];
   assign is_and   = opc == iab_pkg::OPC_AND && tail_zero;
   assign is_andi  = opc == iab_pkg::OPC_ANDI;
   assign is_andn  = opc == iab_pkg::OPC_ANDN && tail_zero;
   assign is_andni = opc == iab_pkg::OPC_ANDNI;
   // Padding between delay flag and source A must be clear
   assign is_br = opc == iab_pkg::OPC_BRZ && tail_zero &&
                  word[iab_pkg::PAD_HI -: iab_pkg::PAD_W] == '0;
   assign is_ztrap = zero_word_trap_param && word == '0;
   assign is_imm   = is_addi | is_andi | is_andni;

   // Operand fetch straight from the register file
   assign opa      = s_ff.regs[ra];
   assign opb      = s_ff.regs[rb];
   assign sext_imm = {{iab_pkg::IMM_W{word[iab_pkg::IMM_W-1]}},
                      word[iab_pkg::IMM_W-1:0]};
   // Prefix upper half replaces the sign extension
   assign imm_op   = instr_i.pfx_valid ?
                     {instr_i.pfx_hi, word[iab_pkg::IMM_W-1:0]} :
                     sext_imm;
   assign br_tgt   = s_ff.pc + opb;
   // A word in the slot hands over to the held target
   assign step_pc  = s_ff.phase == iab_pkg::PH_SLOT ? s_ff.target :
                     s_ff.pc + iab_pkg::PC_STEP;

   // Operation select; carry-in only for add families
   assign alu_req.op  = (is_and | is_andi) ? iab_pkg::ALU_AND :
                        (is_andn | is_andni) ? iab_pkg::ALU_ANDN :
                        iab_pkg::ALU_ADD;
   assign alu_req.a   = opa;
   assign alu_req.b   = is_imm ? imm_op : opb;
   assign alu_req.cin = word[iab_pkg::BIT_CIN] & s_ff.carry &
                        (is_add | is_addi);

   iab_alu u_alu (
      .req_i (alu_req),
      .rsp_o (alu_rsp)
   );

   // Byte-lane merge for partial bus writes
   function automatic iab_word_t merge_lanes(input iab_word_t old_v,
      input iab_word_t new_v, input logic [iab_pkg::LANES-1:0] sel);
      iab_word_t m;
      m = old_v;
      for (int i = 0; i < iab_pkg::LANES; i++) begin
         if (sel[i]) begin
            m[i*iab_pkg::BYTE_W +: iab_pkg::BYTE_W] =
               new_v[i*iab_pkg::BYTE_W +: iab_pkg::BYTE_W];
         end
      end
      return m;
   endfunction

   // Next-state logic: bus first, execution after so its sets win
   always_comb begin
      nxt_s        = s_ff;
      nxt_s.trap_p = 1'b0;
      nxt_s.ack    = 1'b0;
      // Bus access, answered one cycle after the strobe
      if (wb_cyc_i && wb_stb_i && !s_ff.ack) begin
         nxt_s.ack   = 1'b1;
         nxt_s.rdata = '0;
         if (wb_adr_i == iab_pkg::ADR_CTRL) begin
            nxt_s.rdata[iab_pkg::CTRL_RUN] = s_ff.run;
            if (wb_we_i && wb_sel_i[0]) begin
               nxt_s.run = wb_dat_i[iab_pkg::CTRL_RUN];
            end
         end else if (wb_adr_i == iab_pkg::ADR_STATUS) begin
            nxt_s.rdata[iab_pkg::ST_CARRY] = s_ff.carry;
            nxt_s.rdata[iab_pkg::ST_TRAP]  = s_ff.trap;
            nxt_s.rdata[iab_pkg::ST_UNSUP] = s_ff.unsup;
            nxt_s.rdata[iab_pkg::ST_SLOT]  = s_ff.slot;
            // Sticky bits clear on writing one
            if (wb_we_i && wb_sel_i[0]) begin
               if (wb_dat_i[iab_pkg::ST_TRAP]) begin
                  nxt_s.trap = 1'b0;
               end
               if (wb_dat_i[iab_pkg::ST_UNSUP]) begin
                  nxt_s.unsup = 1'b0;
               end
               // Carry only loadable while halted
               if (!s_ff.run) begin
                  nxt_s.carry = wb_dat_i[iab_pkg::ST_CARRY];
               end
            end
         end else if (wb_adr_i == iab_pkg::ADR_PC) begin
            nxt_s.rdata = s_ff.pc;
            if (wb_we_i && !s_ff.run) begin
               nxt_s.pc = merge_lanes(s_ff.pc, wb_dat_i, wb_sel_i);
            end
         end else if (wb_adr_i == iab_pkg::ADR_REG_IDX) begin
            nxt_s.rdata[iab_pkg::RIDX_W-1:0] = s_ff.ridx;
            if (wb_we_i && wb_sel_i[0]) begin
               nxt_s.ridx = wb_dat_i[iab_pkg::RIDX_W-1:0];
            end
         end else if (wb_adr_i == iab_pkg::ADR_REG_DATA) begin
            nxt_s.rdata = s_ff.regs[s_ff.ridx];
            // Halted only, so the bus never races an execute write
            if (wb_we_i && !s_ff.run) begin
               nxt_s.regs[s_ff.ridx] = merge_lanes(s_ff.regs[s_ff.ridx],
                                                   wb_dat_i, wb_sel_i);
            end
         end
      end
      // Bubble countdown after a taken branch
      case (s_ff.phase)
         iab_pkg::PH_STALL: begin
            nxt_s.stall = s_ff.stall - 2'h1;
            if (s_ff.stall == iab_pkg::STALL_LAST) begin
               nxt_s.phase = s_ff.dly ? iab_pkg::PH_SLOT :
                                        iab_pkg::PH_ISSUE;
            end
         end
         default: begin
            nxt_s.stall = s_ff.stall;
         end
      endcase
      // Execute the word taken this cycle
      if (fire) begin
         nxt_s.pc    = step_pc;
         nxt_s.phase = iab_pkg::PH_ISSUE;
         if (is_ztrap) begin
            nxt_s.trap_p = 1'b1;
            nxt_s.trap   = 1'b1;
         end else if (is_add || is_addi) begin
            nxt_s.regs[rd] = alu_rsp.res;
            if (!word[iab_pkg::BIT_KEEP]) begin
               nxt_s.carry = alu_rsp.cout;
            end
         end else if (is_and || is_andi || is_andn || is_andni) begin
            // Carry flag deliberately left alone
            nxt_s.regs[rd] = alu_rsp.res;
         end else if (is_br) begin
            // A branch in the slot is not expected here
            if (opa == '0 && s_ff.phase != iab_pkg::PH_SLOT) begin
               nxt_s.phase  = iab_pkg::PH_STALL;
               nxt_s.target = br_tgt;
               nxt_s.dly    = word[iab_pkg::BIT_DLY];
               if (word[iab_pkg::BIT_DLY]) begin
                  // Slot word at the next address runs first
                  nxt_s.pc    = s_ff.pc + iab_pkg::PC_STEP;
                  nxt_s.stall = 2'(iab_pkg::CYC_TAKEN_DLY - 1);
               end else begin
                  nxt_s.pc    = br_tgt;
                  nxt_s.stall = 2'(iab_pkg::CYC_TAKEN - 1);
               end
            end
         end else begin
            nxt_s.unsup = 1'b1;
         end
      end
      // Offer only while running and not in a bubble
      nxt_s.ready = nxt_s.run && nxt_s.phase != iab_pkg::PH_STALL;
      nxt_s.slot  = nxt_s.phase == iab_pkg::PH_SLOT;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff    <= '0;
         s_ff.pc <= iab_pkg::PC_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign instr_ready_o = s_ff.ready;
   assign pc_o          = s_ff.pc;
   assign carry_o       = s_ff.carry;
   assign trap_o        = s_ff.trap_p;
   assign slot_o        = s_ff.slot;
   assign wb_dat_o      = s_ff.rdata;
   assign wb_ack_o      = s_ff.ack;

   // Reference values for the checks below
   logic [iab_pkg::XLEN:0] exp_sum;  // Independent add with carry-out
   iab_word_t              exp_res;  // Expected sum
   logic                   exp_cout; // Expected carry-out
   logic                   arith;    // Add family taken, no trap
   logic                   logic_op; // Logic family taken
   assign exp_sum  = {1'b0, opa} + {1'b0, (is_addi ? imm_op : opb)} +
                     {{iab_pkg::XLEN{1'b0}},
                      word[iab_pkg::BIT_CIN] & s_ff.carry};
   assign exp_res  = exp_sum[iab_pkg::XLEN-1:0];
   assign exp_cout = exp_sum[iab_pkg::XLEN];
   assign arith    = fire && (is_add || is_addi) && !is_ztrap;
   assign logic_op = fire && (is_and || is_andi || is_andn || is_andni);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_two_bubbles;
      !instr_ready_o ##1 !instr_ready_o ##1 (s_ff.phase == iab_pkg::PH_ISSUE);
   endsequence
   sequence seq_one_bubble;
      !instr_ready_o ##1 (slot_o && s_ff.phase == iab_pkg::PH_SLOT);
   endsequence

   a_add_sum: assert property (arith && is_add |=>
      s_ff.regs[$past(rd)] == $past(exp_res))
      else $error("register add result wrong");
   a_keep_carry: assert property (arith && word[iab_pkg::BIT_KEEP] |=>
      $stable(s_ff.carry)) else $error("carry changed on keep");
   a_load_carry: assert property (arith && !word[iab_pkg::BIT_KEEP] |=>
      carry_o == $past(exp_cout)) else $error("carry not loaded");
   a_carry_in: assert property (arith && is_add &&
      word[iab_pkg::BIT_CIN] && s_ff.carry |=>
      s_ff.regs[$past(rd)] == $past(opa) + $past(opb) + 32'h1)
      else $error("carry-in not added");
   a_zero_trap: assert property (fire && word == '0 |=>
      trap_o == zero_word_trap_param ##1 !trap_o)
      else $error("zero word trap wrong");
   a_imm_sext: assert property (arith && is_addi && !instr_i.pfx_valid &&
      !word[iab_pkg::BIT_CIN] |=>
      s_ff.regs[$past(rd)] == $past(opa) + $past(sext_imm))
      else $error("immediate add wrong");
   a_imm_prefix: assert property (fire && is_andni && instr_i.pfx_valid |=>
      s_ff.regs[$past(rd)] == ($past(opa) &
      ~{$past(instr_i.pfx_hi), $past(word[iab_pkg::IMM_W-1:0])}))
      else $error("prefix literal not used");
   a_and_res: assert property (fire && is_and |=>
      s_ff.regs[$past(rd)] == ($past(opa) & $past(opb)))
      else $error("and result wrong");
   a_andn_res: assert property (fire && is_andn |=>
      s_ff.regs[$past(rd)] == ($past(opa) & ~$past(opb)))
      else $error("and-not result wrong");
   a_andni_res: assert property (fire && is_andni &&
      !instr_i.pfx_valid |=>
      s_ff.regs[$past(rd)] == ($past(opa) & ~$past(sext_imm)))
      else $error("and-not immediate wrong");
   a_logic_carry: assert property (logic_op |=> $stable(carry_o))
      else $error("logic op touched carry");
   a_br_pad: assert property (fire && opc == iab_pkg::OPC_BRZ &&
      word[iab_pkg::PAD_HI -: iab_pkg::PAD_W] != '0 |=> s_ff.unsup)
      else $error("bad branch padding accepted");
   a_not_taken: assert property (fire && is_br && opa != '0 &&
      s_ff.phase == iab_pkg::PH_ISSUE |=>
      pc_o == $past(pc_o) + iab_pkg::PC_STEP &&
      s_ff.phase == iab_pkg::PH_ISSUE) else $error("not-taken branch wrong");
   a_taken_nodly: assert property (fire && is_br && opa == '0 &&
      !word[iab_pkg::BIT_DLY] && s_ff.phase == iab_pkg::PH_ISSUE |=>
      (pc_o == $past(pc_o) + $past(opb)) and seq_two_bubbles)
      else $error("taken branch timing wrong");
   a_taken_dly: assert property (fire && is_br && opa == '0 &&
      word[iab_pkg::BIT_DLY] && s_ff.phase == iab_pkg::PH_ISSUE |=>
      seq_one_bubble) else $error("delayed branch timing wrong");
   a_slot_target: assert property (fire && slot_o |=>
      pc_o == $past(s_ff.target) && !slot_o)
      else $error("slot did not hand over to target");

endmodule // iab_exec

// [verif/iab_fetch_model.sv]
`timescale 1ns/10ps
// Fetch stage model: program memory offering the word at the requested PC
module iab_fetch_model (
   // Request from the block
   input  wire  logic [iab_pkg::XLEN-1:0] pc_i,
   // Offered word
   output iab_pkg::iab_instr_t            instr_o
);
   logic [31:0] mem [16]; // Program words
   logic [3:0]  idx;      // Word index from the PC

   // Fixed program; the slot word 12 is an immediate add, never prefix or branch
   initial begin
      mem[0]  = {6'h00, 5'd6, 5'd1, 5'd2, 11'h000};   // Add, carry out
      mem[1]  = {6'h02, 5'd7, 5'd2, 5'd2, 11'h000};   // Add with carry-in
      mem[2]  = {6'h04, 5'd8, 5'd1, 5'd1, 11'h000};   // Add, keep carry
      mem[3]  = {6'h08, 5'd9, 5'd2, 16'h8000};        // Immediate add
      mem[4]  = {6'h29, 5'd10, 5'd1, 16'h8001};       // AND immediate
      mem[5]  = {6'h21, 5'd11, 5'd5, 5'd1, 11'h000};  // AND
      mem[6]  = {6'h23, 5'd12, 5'd1, 5'd5, 11'h000};  // AND-NOT
      mem[7]  = {6'h2b, 5'd13, 5'd1, 16'hff00};       // AND-NOT imm, prefix
      mem[8]  = {6'h27, 5'd0, 5'd3, 5'd4, 11'h000};   // Taken, no delay
      mem[9]  = {6'h27, 5'd1, 5'd3, 5'd4, 11'h000};   // Bad padding, skipped
      mem[10] = {6'h27, 5'd0, 5'd2, 5'd4, 11'h000};   // Not taken
      mem[11] = {6'h27, 5'd16, 5'd3, 5'd4, 11'h000};  // Taken with delay
      mem[12] = {6'h08, 5'd15, 5'd2, 16'h0005};       // Delay-slot word
      mem[13] = {6'h0a, 5'd16, 5'd1, 16'h0001};       // Imm add, carry-in
      mem[14] = {6'h06, 5'd17, 5'd2, 5'd2, 11'h000};  // Carry-in, keep
      mem[15] = 32'h0000_0000;                        // Zero word
   end

   assign idx = pc_i[5:2];

   // Outside the program the bus shows inverted junk, not the last word
   always_comb begin
      instr_o.valid     = (pc_i < 32'h0000_0040);
      instr_o.word      = instr_o.valid ? mem[idx] : ~mem[idx];
      instr_o.pfx_valid = instr_o.valid && (idx == 4'h7);
      instr_o.pfx_hi    = instr_o.valid ? 16'h0000 : 16'hffff;
   end
endmodule // iab_fetch_model

// [verif/tb_top.sv]
`timescale 1ns/10ps
// Loads registers, runs the fetch program, checks results and timing
module tb_top;
   logic                clk_i;      // Bench clock
   logic                rst_i;      // Synchronous reset
   logic                wb_cyc;     // Bus cycle
   logic                wb_stb;     // Bus strobe
   logic                wb_we;      // Bus direction
   logic [7:0]          wb_adr;     // Bus address
   logic [3:0]          wb_sel;     // Byte lanes
   logic [31:0]         wb_wdat;    // Write data
   logic [31:0]         wb_rdat;    // Read data
   logic                wb_ack;     // Bus answer
   iab_pkg::iab_instr_t instr;      // Word from fetch
   logic                ready;      // Block offering to take a word
   logic [31:0]         pc;         // Requested address
   logic                carry;      // Carry flag
   logic                trap;       // Trap pulse
   logic                slot;       // Delay-slot marker
   logic                counting;   // Measurement window
   int                  n_bubble = 0; // Stalled fetch cycles
   int                  n_trap = 0;   // Trap pulses seen
   int                  n_slot = 0;   // Slot words taken
   int                  n_errors;   // Mismatches
   int                  comparisons; // Compares made
   logic [31:0]         q;          // Read result
   int                  n;          // Wait counter
   // Final register contents; 1 to 5 are also the loaded values
   localparam logic [31:0] EXP [18] = '{32'h0, 32'hffffffff, 32'h1,
      32'h0, 32'h8, 32'hf0f, 32'h0, 32'h3, 32'hfffffffe, 32'hffff8001,
      32'hffff8001, 32'hf0f, 32'hfffff0f0, 32'hffff00ff, 32'h0, 32'h6,
      32'h0, 32'h3};

   iab_exec #(.zero_word_trap_param(1'b1)) dut (.clk_i(clk_i),
      .rst_i(rst_i), .instr_i(instr), .instr_ready_o(ready), .pc_o(pc),
      .carry_o(carry), .trap_o(trap), .slot_o(slot), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack));
   iab_fetch_model u_fetch (.pc_i(pc), .instr_o(instr));

   // Clock at 100 ns period
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a,
         4'hf, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack !== 1'b1 && k < 20);
      r = wb_rdat;
      check("wb_ack", {31'h0, wb_ack}, 32'h1);
      {wb_cyc, wb_stb} <= 2'b00;
      @(posedge clk_i);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Stall, trap and slot counters inside the run window
   always @(posedge clk_i) begin
      if (counting && ready === 1'b0 && pc !== 32'h0) n_bubble <= n_bubble + 1;
      if (counting && trap === 1'b1) n_trap <= n_trap + 1;
      if (counting && slot && ready && instr.valid) n_slot <= n_slot + 1;
   end

   // Cuts a hang short
   initial begin
      #(3000 * 100);
      n_errors++;
      summarize();
   end

   initial begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
      {n_errors, comparisons} = '0;
      counting = 1'b0;
      rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("pc_o", pc, iab_pkg::PC_RST);
      check("carry_o", {31'h0, carry}, 32'h0);
      wb(1'b0, 8'hfc, 32'h0, q);
      check("unmapped", q, 32'h0);
      $display("test reset done");
      // Load source registers while halted
      for (int i = 1; i < 6; i++) begin
         wb(1'b1, iab_pkg::ADR_REG_IDX, i, q);
         wb(1'b1, iab_pkg::ADR_REG_DATA, EXP[i], q);
      end
      counting <= 1'b1;
      wb(1'b1, iab_pkg::ADR_CTRL, 32'h1, q);
      n = 0;
      while (pc !== 32'h40 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      counting <= 1'b0;
      @(posedge clk_i);
      wb(1'b1, iab_pkg::ADR_CTRL, 32'h0, q);
      check("pc_o end", pc, 32'h40);
      check("stall cycles", n_bubble, 3);
      check("trap pulses", n_trap, 1);
      check("slot words", n_slot, 1);
      $display("test program done");
      for (int i = 0; i < 18; i++) begin
         wb(1'b1, iab_pkg::ADR_REG_IDX, i, q);
         wb(1'b0, iab_pkg::ADR_REG_DATA, 32'h0, q);
         check("register", q, EXP[i]);
      end
      wb(1'b0, iab_pkg::ADR_STATUS, 32'h0, q);
      check("status", q, 32'h3);
      check("carry_o", {31'h0, carry}, 32'h1);
      $display("test results done");
      // Rerun from the skipped word, whose branch padding is bad
      wb(1'b1, iab_pkg::ADR_PC, 32'h24, q);
      check("pc_o write", pc, 32'h24);
      wb(1'b1, iab_pkg::ADR_CTRL, 32'h1, q);
      n = 0;
      while (pc !== 32'h40 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      wb(1'b1, iab_pkg::ADR_CTRL, 32'h0, q);
      wb(1'b0, iab_pkg::ADR_STATUS, 32'h0, q);
      check("status unsup", q, 32'h7);
      // Sticky bits clear on one; carry loads while halted
      wb(1'b1, iab_pkg::ADR_STATUS, 32'h6, q);
      wb(1'b0, iab_pkg::ADR_STATUS, 32'h0, q);
      check("status clear", q, 32'h0);
      $display("test rerun done");
      summarize();
   end
endmodule // tb_top
